// ==== rtl/flash_host_pkg.sv ====
package flash_host_pkg;
  // ----------------------------------------
  // bus geometry
  // ----------------------------------------
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  // ----------------------------------------
  // command codes and unlock addresses
  // ----------------------------------------
  localparam logic [7:0] CODE_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
  localparam logic [7:0] CODE_RESET = 8'hF0;
  localparam logic [7:0] CODE_IDENT = 8'h90;
  localparam logic [7:0] CODE_QUERY = 8'h98;
  localparam logic [7:0] CODE_SECURE = 8'h88;
  localparam logic [7:0] CODE_EXIT = 8'h00;
  localparam logic [7:0] CODE_PROG = 8'hA0;
  localparam logic [7:0] CODE_FAST = 8'h20;
  localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CODE_CHIP = 8'h10;
  localparam logic [7:0] CODE_SECTOR = 8'h30;
  localparam logic [7:0] CODE_PAUSE = 8'hB0;
  localparam logic [7:0] CODE_RESUME = 8'h30;
  localparam logic [11:0] WORD_UNLOCK_A = 12'h555;
  localparam logic [11:0] WORD_UNLOCK_B = 12'h2AA;
  localparam logic [11:0] BYTE_UNLOCK_A = 12'hAAA;
  localparam logic [11:0] BYTE_UNLOCK_B = 12'h555;
  localparam logic [11:0] WORD_QUERY_A = 12'h055;
  localparam logic [11:0] BYTE_QUERY_A = 12'h0AA;
  localparam logic [11:0] ANY_ADDR = 12'h000;
  localparam logic [11:0] ID_MAKER_OFS = 12'h000;
  localparam logic [11:0] WORD_PART_OFS = 12'h001;
  localparam logic [11:0] BYTE_PART_OFS = 12'h002;
  localparam logic [11:0] WORD_PROT_OFS = 12'h002;
  localparam logic [11:0] BYTE_PROT_OFS = 12'h004;
  localparam int LOW_ADDR_W = 11;
  localparam int SECTOR_LSB = 12;
  // ----------------------------------------
  // host commands
  // ----------------------------------------
  typedef enum logic [3:0] {
    OP_READ = 4'h0, OP_RESET = 4'h1, OP_IDENT = 4'h2, OP_QUERY = 4'h3,
    OP_SEC_ENTER = 4'h4, OP_SEC_EXIT = 4'h5, OP_PROGRAM = 4'h6,
    OP_FAST_ENTER = 4'h7, OP_FAST_PROG = 4'h8, OP_FAST_EXIT = 4'h9,
    OP_CHIP_ERASE = 4'hA, OP_SECT_ERASE = 4'hB, OP_SECT_ADD = 4'hC,
    OP_PAUSE = 4'hD, OP_RESUME = 4'hE, OP_ID_READ = 4'hF
  } op_t;
  // ----------------------------------------
  // bus-cycle timing, 25 MHz reference
  // ----------------------------------------
  localparam int CLK_NS = 40;
  localparam int SETUP_NS = 40;
  localparam int PULSE_NS = 80;
  localparam int HOLD_NS = 40;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int MAX_CYCLES = 6;
endpackage

// ==== rtl/flash_cycle_if.sv ====
`timescale 1ns/1ps
interface flash_cycle_if;
  import flash_host_pkg::*;
  logic start;
  logic is_read;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic done;
  logic [DATA_W-1:0] rdata;
  modport seq (output start, output is_read, output addr, output wdata,
    input done, input rdata);
  modport phy (input start, input is_read, input addr, input wdata,
    output done, output rdata);
endinterface

// ==== rtl/flash_bus_cycle.sv ====
`timescale 1ns/1ps
module flash_bus_cycle
  import flash_host_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  flash_cycle_if.phy cyc,
  output logic ce_n,
  output logic we_n,
  output logic oe_n,
  output logic [ADDR_W-1:0] addr_out,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe_n,
  input wire logic [DATA_W-1:0] dq_in
);
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00, PH_SETUP = 2'b01, PH_PULSE = 2'b10, PH_HOLD = 2'b11
  } phase_t;
  phase_t ph_r;
  logic [3:0] cnt_r;
  logic rd_r;
  logic done_r;
  logic [DATA_W-1:0] rdata_r;

  assign cyc.done = done_r;
  assign cyc.rdata = rdata_r;

  // one write or read: setup, strobe low, hold; ce falls at setup start, we or oe one setup period later
  always_ff @(posedge clk) begin
    done_r <= 1'b0;
    if (rst) begin
      ph_r <= PH_IDLE;
      cnt_r <= 4'h0;
      rd_r <= 1'b0;
      ce_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
      dq_oe_n <= 1'b1;
      addr_out <= '0;
      dq_out <= '0;
      rdata_r <= '0;
    end else begin
      case (ph_r)
        PH_IDLE: begin
          if (cyc.start) begin
            rd_r <= cyc.is_read;
            addr_out <= cyc.addr;
            dq_out <= cyc.wdata;
            dq_oe_n <= cyc.is_read;
            ce_n <= 1'b0;
            cnt_r <= 4'(SETUP_CYC);
            ph_r <= PH_SETUP;
          end
        end
        PH_SETUP: begin
          cnt_r <= cnt_r - 4'h1;
          if (cnt_r == 4'h1) begin
            // location latched on the later falling edge
            we_n <= rd_r;
            oe_n <= ~rd_r;
            cnt_r <= 4'(PULSE_CYC);
            ph_r <= PH_PULSE;
          end
        end
        PH_PULSE: begin
          cnt_r <= cnt_r - 4'h1;
          if (cnt_r == 4'h1) begin
            // data held stable across the first rising edge
            we_n <= 1'b1;
            oe_n <= 1'b1;
            if (rd_r)
              rdata_r <= dq_in;
            cnt_r <= 4'(HOLD_CYC);
            ph_r <= PH_HOLD;
          end
        end
        PH_HOLD: begin
          cnt_r <= cnt_r - 4'h1;
          if (cnt_r == 4'h1) begin
            ce_n <= 1'b1;
            dq_oe_n <= 1'b1;
            done_r <= 1'b1;
            ph_r <= PH_IDLE;
          end
        end
        default: ph_r <= PH_IDLE;
      endcase
    end
  end
endmodule // flash_bus_cycle

// ==== rtl/flash_cmd_host.sv ====
`timescale 1ns/1ps
module flash_cmd_host
  import flash_host_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic BYTE_MODE,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire flash_host_pkg::op_t REQ_OP,
  input wire logic [flash_host_pkg::ADDR_W-1:0] REQ_ADDR,
  input wire logic [flash_host_pkg::DATA_W-1:0] REQ_DATA,
  input wire logic FAST_MODE,
  output logic RSP_VALID,
  output logic [flash_host_pkg::DATA_W-1:0] RSP_DATA,
  output logic REFUSED,
  output logic CE_N,
  output logic WE_N,
  output logic OE_N,
  output logic [flash_host_pkg::ADDR_W-1:0] ADDR,
  output logic [flash_host_pkg::DATA_W-1:0] DQ_OUT,
  output logic DQ_OE_N,
  input wire logic [flash_host_pkg::DATA_W-1:0] DQ_IN
);
  import flash_host_pkg::*;

  // ----------------------------------------
  // sequence storage
  // ----------------------------------------
  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_ISSUE = 2'b01, S_WAIT = 2'b10
  } state_t;
  state_t state_r;
  logic [2:0] len_r;
  logic [2:0] idx_r;
  logic [ADDR_W-1:0] seq_addr_r [MAX_CYCLES];
  logic [DATA_W-1:0] seq_data_r [MAX_CYCLES];
  logic last_read_r;
  logic fast_r;
  logic refused_r;
  logic rsp_r;
  logic [DATA_W-1:0] rsp_data_r;
  logic accept;
  logic ok;
  logic [2:0] len_nxt;
  logic [ADDR_W-1:0] a_nxt [MAX_CYCLES];
  logic [DATA_W-1:0] d_nxt [MAX_CYCLES];
  logic rd_nxt;

  flash_cycle_if cif ();

  flash_bus_cycle u_cycle (
    .clk(REF_CLK),
    .rst(RST),
    .cyc(cif.phy),
    .ce_n(CE_N),
    .we_n(WE_N),
    .oe_n(OE_N),
    .addr_out(ADDR),
    .dq_out(DQ_OUT),
    .dq_oe_n(DQ_OE_N),
    .dq_in(DQ_IN)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // low address only; upper bits zero where no location is needed
  function automatic logic [ADDR_W-1:0] low_addr(input logic [11:0] a);
    return {{(ADDR_W-12){1'b0}}, a};
  endfunction

  // command code on low byte, upper byte driven zero
  function automatic logic [DATA_W-1:0] code(input logic [7:0] c);
    return {{(DATA_W-8){1'b0}}, c};
  endfunction

  // word or byte mode unlock addresses
  function automatic logic [11:0] unl_a(input logic bm);
    return bm ? BYTE_UNLOCK_A : WORD_UNLOCK_A;
  endfunction

  function automatic logic [11:0] unl_b(input logic bm);
    return bm ? BYTE_UNLOCK_B : WORD_UNLOCK_B;
  endfunction

  // ----------------------------------------
  // sequence builder
  // ----------------------------------------
  always_comb begin
    len_nxt = 3'd0;
    rd_nxt = 1'b0;
    ok = 1'b1;
    for (int i = 0; i < MAX_CYCLES; i++) begin
      a_nxt[i] = '0;
      d_nxt[i] = '0;
    end
    // shared unlock prefix
    a_nxt[0] = low_addr(unl_a(BYTE_MODE));
    d_nxt[0] = code(CODE_UNLOCK1);
    a_nxt[1] = low_addr(unl_b(BYTE_MODE));
    d_nxt[1] = code(CODE_UNLOCK2);
    a_nxt[2] = low_addr(unl_a(BYTE_MODE));
    case (REQ_OP)
      OP_READ, OP_ID_READ: begin
        // plain read, no command cycles
        a_nxt[0] = REQ_ADDR;
        d_nxt[0] = '0;
        len_nxt = 3'd1;
        rd_nxt = 1'b1;
      end
      OP_RESET: begin
        a_nxt[0] = low_addr(ANY_ADDR);
        d_nxt[0] = code(CODE_RESET);
        len_nxt = 3'd1;
      end
      OP_IDENT: begin
        d_nxt[2] = code(CODE_IDENT);
        len_nxt = 3'd3;
      end
      OP_QUERY: begin
        a_nxt[0] = low_addr(BYTE_MODE ? BYTE_QUERY_A : WORD_QUERY_A);
        d_nxt[0] = code(CODE_QUERY);
        len_nxt = 3'd1;
      end
      OP_SEC_ENTER: begin
        d_nxt[2] = code(CODE_SECURE);
        len_nxt = 3'd3;
      end
      OP_SEC_EXIT: begin
        d_nxt[2] = code(CODE_IDENT);
        a_nxt[3] = low_addr(ANY_ADDR);
        d_nxt[3] = code(CODE_EXIT);
        len_nxt = 3'd4;
      end
      OP_PROGRAM: begin
        d_nxt[2] = code(CODE_PROG);
        a_nxt[3] = REQ_ADDR;
        d_nxt[3] = REQ_DATA;
        len_nxt = 3'd4;
      end
      OP_FAST_ENTER: begin
        d_nxt[2] = code(CODE_FAST);
        len_nxt = 3'd3;
      end
      OP_FAST_PROG: begin
        a_nxt[0] = low_addr(ANY_ADDR);
        d_nxt[0] = code(CODE_PROG);
        a_nxt[1] = REQ_ADDR;
        d_nxt[1] = REQ_DATA;
        len_nxt = 3'd2;
        ok = fast_r; // short program refused outside fast mode
      end
      OP_FAST_EXIT: begin
        a_nxt[0] = low_addr(ANY_ADDR);
        d_nxt[0] = code(CODE_IDENT);
        a_nxt[1] = low_addr(ANY_ADDR);
        d_nxt[1] = code(CODE_EXIT);
        len_nxt = 3'd2;
      end
      OP_CHIP_ERASE, OP_SECT_ERASE: begin
        d_nxt[2] = code(CODE_ERASE_SETUP);
        a_nxt[3] = low_addr(unl_a(BYTE_MODE));
        d_nxt[3] = code(CODE_UNLOCK1);
        a_nxt[4] = low_addr(unl_b(BYTE_MODE));
        d_nxt[4] = code(CODE_UNLOCK2);
        // sector chosen by the sector select bits
        a_nxt[5] = (REQ_OP == OP_CHIP_ERASE) ? low_addr(unl_a(BYTE_MODE)) : REQ_ADDR;
        d_nxt[5] = code((REQ_OP == OP_CHIP_ERASE) ? CODE_CHIP : CODE_SECTOR);
        len_nxt = 3'd6;
      end
      OP_SECT_ADD: begin
        a_nxt[0] = REQ_ADDR;
        d_nxt[0] = code(CODE_SECTOR);
        len_nxt = 3'd1;
      end
      OP_PAUSE: begin
        a_nxt[0] = low_addr(ANY_ADDR);
        d_nxt[0] = code(CODE_PAUSE);
        len_nxt = 3'd1;
      end
      OP_RESUME: begin
        a_nxt[0] = low_addr(ANY_ADDR);
        d_nxt[0] = code(CODE_RESUME);
        len_nxt = 3'd1;
      end
      default: ok = 1'b0;
    endcase
  end

  assign REQ_READY = (state_r == S_IDLE);
  assign accept = REQ_VALID && REQ_READY;
  assign REFUSED = refused_r;
  assign RSP_VALID = rsp_r;
  assign RSP_DATA = rsp_data_r;
  assign cif.start = (state_r == S_ISSUE);
  assign cif.is_read = last_read_r && (idx_r == len_r - 3'd1);
  assign cif.addr = seq_addr_r[idx_r];
  assign cif.wdata = seq_data_r[idx_r];

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    rsp_r <= 1'b0;
    refused_r <= 1'b0;
    if (RST) begin
      state_r <= S_IDLE;
      len_r <= 3'd0;
      idx_r <= 3'd0;
      last_read_r <= 1'b0;
      rsp_data_r <= '0;
      for (int i = 0; i < MAX_CYCLES; i++) begin
        seq_addr_r[i] <= '0;
        seq_data_r[i] <= '0;
      end
    end else begin
      case (state_r)
        S_IDLE: begin
          if (accept && !ok) begin
            refused_r <= 1'b1;
          end else if (accept) begin
            for (int i = 0; i < MAX_CYCLES; i++) begin
              seq_addr_r[i] <= a_nxt[i];
              seq_data_r[i] <= d_nxt[i];
            end
            len_r <= len_nxt;
            last_read_r <= rd_nxt;
            idx_r <= 3'd0;
            state_r <= S_ISSUE;
          end
        end
        S_ISSUE: state_r <= S_WAIT;
        S_WAIT: begin
          if (cif.done) begin
            if (idx_r == len_r - 3'd1) begin
              rsp_r <= 1'b1;
              rsp_data_r <= last_read_r ? cif.rdata : '0;
              state_r <= S_IDLE;
            end else begin
              idx_r <= idx_r + 3'd1;
              state_r <= S_ISSUE;
            end
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // fast-mode tracking
  // ----------------------------------------
  // FAST_MODE input lets software assume the mode after a device-side entry
  always_ff @(posedge REF_CLK) begin
    if (RST)
      fast_r <= 1'b0;
    else if (accept && REQ_OP == OP_FAST_ENTER)
      fast_r <= 1'b1;
    else if (accept && (REQ_OP == OP_FAST_EXIT || REQ_OP == OP_RESET))
      fast_r <= 1'b0;
    else if (FAST_MODE)
      fast_r <= 1'b1;
  end
endmodule // flash_cmd_host

// ==== bench/flash_cmd_host_props.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// bus cycle checks
// ----------------------------------------
module flash_cmd_host_props (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic REFUSED,
  input wire logic RSP_VALID,
  input wire logic CE_N,
  input wire logic WE_N,
  input wire logic OE_N,
  input wire logic [flash_host_pkg::ADDR_W-1:0] ADDR,
  input wire logic [flash_host_pkg::DATA_W-1:0] DQ_OUT,
  input wire logic DQ_OE_N
);
  import flash_host_pkg::*;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  a_strobe_excl: assert property (!(!WE_N && !OE_N))
    else $error("write and read strobes low together");
  a_write_drives: assert property (!WE_N |-> !DQ_OE_N && !CE_N)
    else $error("write strobe without select or drive");
  a_read_floats: assert property (!OE_N |-> DQ_OE_N && !CE_N)
    else $error("read strobe while driving the bus");
  a_write_width: assert property ($fell(WE_N) |=> !WE_N ##1 WE_N)
    else $error("write pulse not two cycles");
  a_write_setup: assert property ($fell(WE_N) |-> $past(!CE_N) && $past(!DQ_OE_N))
    else $error("write strobe without setup");
  a_write_stable: assert property (!WE_N && $past(!WE_N) |-> $stable(ADDR) && $stable(DQ_OUT))
    else $error("address or data moved in write pulse");
  a_data_hold: assert property ($rose(WE_N) |-> !CE_N && !DQ_OE_N ##1 CE_N)
    else $error("no hold after write strobe");
  a_refuse_quiet: assert property (REFUSED |-> CE_N && !RSP_VALID)
    else $error("refused request touched the bus");
  a_read_answer: assert property ($rose(OE_N) |-> ##[1:6] RSP_VALID)
    else $error("read without response");
  a_rsp_pulse: assert property (RSP_VALID |=> !RSP_VALID)
    else $error("response longer than one cycle");
endmodule // flash_cmd_host_props

bind flash_cmd_host flash_cmd_host_props u_flash_cmd_host_props (.REF_CLK(REF_CLK), .RST(RST),
  .REFUSED(REFUSED), .RSP_VALID(RSP_VALID), .CE_N(CE_N), .WE_N(WE_N), .OE_N(OE_N),
  .ADDR(ADDR), .DQ_OUT(DQ_OUT), .DQ_OE_N(DQ_OE_N));

// ==== bench/flash_dev_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// behavioural flash device
// ----------------------------------------
module flash_dev_model #(
  parameter logic [15:0] MAKER_ID = 16'h005A, // arbitrary value
  parameter logic [15:0] PART_ID = 16'h3C3C // arbitrary value
) (
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic byte_mode,
  input wire logic [flash_host_pkg::ADDR_W-1:0] addr,
  input wire logic [flash_host_pkg::DATA_W-1:0] dq,
  output logic [flash_host_pkg::DATA_W-1:0] dq_in
);
  import flash_host_pkg::*;
  logic [DATA_W-1:0] mem [16];
  logic [ADDR_W-1:0] lat_a = 20'h00000;
  logic [11:0] ua;
  logic [11:0] ub;
  logic [1:0] step = 2'h0;
  logic ident = 1'b0;
  logic prog = 1'b0;
  initial dq_in = 16'h0000;
  assign ua = byte_mode ? BYTE_UNLOCK_A : WORD_UNLOCK_A;
  assign ub = byte_mode ? BYTE_UNLOCK_B : WORD_UNLOCK_B;
  always @(negedge we_n) if (!ce_n) lat_a = addr;
  // commands decode only the low byte; program data is stored as the full word
  always @(posedge we_n) if (!ce_n) begin
    if (prog) begin
      mem[lat_a[3:0]] = dq;
      prog = 1'b0;
    end else if (dq[7:0] == CODE_RESET) begin
      ident = 1'b0;
      step = 2'h0;
    end else if (step == 2'h0 && lat_a[11:0] == ua && dq[7:0] == CODE_UNLOCK1) begin
      step = 2'h1;
    end else if (step == 2'h1 && lat_a[11:0] == ub && dq[7:0] == CODE_UNLOCK2) begin
      step = 2'h2;
    end else if (step == 2'h2 && lat_a[11:0] == ua) begin
      ident = dq[7:0] == CODE_IDENT;
      prog = dq[7:0] == CODE_PROG;
      step = 2'h0;
    end else begin
      step = 2'h0;
    end
  end
  // sectors with the lowest select bit set read back as protected
  always @(negedge oe_n) begin
    if (!ident) dq_in = mem[addr[3:0]];
    else if (addr[11:0] == ID_MAKER_OFS) dq_in = MAKER_ID;
    else if (addr[11:0] == (byte_mode ? BYTE_PART_OFS : WORD_PART_OFS)) dq_in = PART_ID;
    else if (addr[11:0] == (byte_mode ? BYTE_PROT_OFS : WORD_PROT_OFS))
      dq_in = {15'h0000, addr[SECTOR_LSB]};
    else dq_in = 16'hFFFF;
  end
  // released bus flips so a late sample cannot pass by luck
  always @(posedge oe_n) dq_in <= #5 ~dq_in;
endmodule // flash_dev_model

// ==== bench/tb.sv ====
`timescale 1ns/1ps
module tb;
  import flash_host_pkg::*;
  localparam logic [15:0] MAKER = 16'h005A; // arbitrary value
  localparam logic [15:0] PART = 16'h3C3C; // arbitrary value
  logic REF_CLK = 1'b0;
  logic RST = 1'b1;
  logic BYTE_MODE = 1'b0;
  logic REQ_VALID = 1'b0;
  logic FAST_MODE = 1'b0;
  op_t REQ_OP = OP_READ;
  logic [ADDR_W-1:0] REQ_ADDR = 20'h00000;
  logic [DATA_W-1:0] REQ_DATA = 16'h0000;
  logic REQ_READY, RSP_VALID, REFUSED, CE_N, WE_N, OE_N, DQ_OE_N;
  logic [DATA_W-1:0] RSP_DATA, DQ_OUT, DQ_IN;
  logic [ADDR_W-1:0] ADDR;
  logic [35:0] wq[$];
  logic [15:0] got;
  logic ref_seen;
  int num_errors = 0;
  int checks_done = 0;
  always #20 REF_CLK = ~REF_CLK;
  // wire monitor: every completed write cycle as seen by the device
  always @(posedge WE_N) if (!RST) wq.push_back({ADDR, DQ_OUT});
  flash_cmd_host u_flash_cmd_host (.REF_CLK(REF_CLK), .RST(RST), .BYTE_MODE(BYTE_MODE),
    .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .REQ_OP(REQ_OP), .REQ_ADDR(REQ_ADDR),
    .REQ_DATA(REQ_DATA), .FAST_MODE(FAST_MODE), .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA),
    .REFUSED(REFUSED), .CE_N(CE_N), .WE_N(WE_N), .OE_N(OE_N), .ADDR(ADDR), .DQ_OUT(DQ_OUT),
    .DQ_OE_N(DQ_OE_N), .DQ_IN(DQ_IN));
  flash_dev_model #(.MAKER_ID(MAKER), .PART_ID(PART)) u_flash_dev_model (.ce_n(CE_N),
    .we_n(WE_N), .oe_n(OE_N), .byte_mode(BYTE_MODE), .addr(ADDR), .dq(DQ_OUT), .dq_in(DQ_IN));
  task automatic results();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [35:0] g, input logic [35:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cnt(input int n);
    chk(36'(wq.size()), 36'(n));
  endtask
  task automatic cw(input int i, input logic [11:0] a, input logic [7:0] c);
    chk(wq[i], {8'h00, a, 8'h00, c});
  endtask
  // don't-care address: only the code is judged
  task automatic cd(input int i, input logic [7:0] c);
    chk(36'(wq[i][15:0]), {28'h0000000, c});
  endtask
  task automatic send(input op_t op, input logic [19:0] a, input logic [15:0] d);
    int n;
    @(posedge REF_CLK);
    wq.delete();
    REQ_OP <= op;
    REQ_ADDR <= a;
    REQ_DATA <= d;
    REQ_VALID <= 1'b1;
    n = 0;
    do begin
      @(negedge REF_CLK);
      n++;
    end while (REQ_READY !== 1'b1 && n < 300);
    @(posedge REF_CLK);
    REQ_VALID <= 1'b0;
    do begin
      @(negedge REF_CLK);
      n++;
      ref_seen = REFUSED === 1'b1;
    end while (RSP_VALID !== 1'b1 && !ref_seen && n < 300);
    got = RSP_DATA;
    if (n >= 300) begin
      num_errors++;
      results();
    end
  endtask
  task automatic t_program();
    send(OP_PROGRAM, 20'h00005, 16'hBEEF);
    cnt(4);
    chk(36'(got), 36'h000000000);
    cw(0, WORD_UNLOCK_A, CODE_UNLOCK1);
    cw(1, WORD_UNLOCK_B, CODE_UNLOCK2);
    cw(2, WORD_UNLOCK_A, CODE_PROG);
    chk(wq[3], {20'h00005, 16'hBEEF});
    send(OP_READ, 20'h00005, 16'h0000);
    cnt(0);
    chk(36'(got), 36'h00000BEEF);
  endtask
  task automatic t_ident();
    @(posedge REF_CLK);
    BYTE_MODE <= 1'b1;
    send(OP_IDENT, 20'h00000, 16'h0000);
    cnt(3);
    cw(0, BYTE_UNLOCK_A, CODE_UNLOCK1);
    cw(1, BYTE_UNLOCK_B, CODE_UNLOCK2);
    cw(2, BYTE_UNLOCK_A, CODE_IDENT);
    send(OP_ID_READ, {8'h00, ID_MAKER_OFS}, 16'h0000);
    chk(36'(got), 36'(MAKER));
    send(OP_ID_READ, {8'h00, BYTE_PART_OFS}, 16'h0000);
    chk(36'(got), 36'(PART));
    send(OP_ID_READ, {8'h01, BYTE_PROT_OFS}, 16'h0000);
    chk(36'(got), 36'h000000001);
    send(OP_ID_READ, {8'h02, BYTE_PROT_OFS}, 16'h0000);
    chk(36'(got), 36'h000000000);
    send(OP_RESET, 20'h00000, 16'h0000);
    cnt(1);
    cd(0, CODE_RESET);
    send(OP_READ, 20'h00005, 16'h0000);
    chk(36'(got), 36'h00000BEEF);
    @(posedge REF_CLK);
    BYTE_MODE <= 1'b0;
  endtask
  task automatic t_fast();
    send(OP_FAST_PROG, 20'h00003, 16'h1234);
    chk(36'(ref_seen), 36'h1);
    cnt(0);
    send(OP_FAST_ENTER, 20'h00000, 16'h0000);
    cnt(3);
    cw(2, WORD_UNLOCK_A, CODE_FAST);
    send(OP_FAST_PROG, 20'h00003, 16'h1234);
    cnt(2);
    cd(0, CODE_PROG);
    chk(wq[1], {20'h00003, 16'h1234});
    send(OP_FAST_EXIT, 20'h00000, 16'h0000);
    cnt(2);
    cd(0, CODE_IDENT);
    cd(1, CODE_EXIT);
    send(OP_FAST_PROG, 20'h00003, 16'h1234);
    chk(36'(ref_seen), 36'h1);
    @(posedge REF_CLK);
    FAST_MODE <= 1'b1;
    @(posedge REF_CLK);
    FAST_MODE <= 1'b0;
    send(OP_FAST_PROG, 20'h00003, 16'h1234);
    chk(36'(ref_seen), 36'h0);
    cnt(2);
    send(OP_RESET, 20'h00000, 16'h0000);
    send(OP_FAST_PROG, 20'h00003, 16'h1234);
    chk(36'(ref_seen), 36'h1);
  endtask
  task automatic t_erase();
    send(OP_SECT_ERASE, 20'h34000, 16'h0000);
    cnt(6);
    cd(2, CODE_ERASE_SETUP);
    cd(3, CODE_UNLOCK1);
    chk(wq[5], {20'h34000, 8'h00, CODE_SECTOR});
    send(OP_SECT_ADD, 20'h35000, 16'h0000);
    cnt(1);
    chk(wq[0], {20'h35000, 8'h00, CODE_SECTOR});
    send(OP_PAUSE, 20'h00000, 16'h0000);
    cd(0, CODE_PAUSE);
    send(OP_RESUME, 20'h00000, 16'h0000);
    cd(0, CODE_RESUME);
    send(OP_CHIP_ERASE, 20'h00000, 16'h0000);
    cnt(6);
    cw(5, WORD_UNLOCK_A, CODE_CHIP);
  endtask
  task automatic t_secure();
    send(OP_SEC_ENTER, 20'h00000, 16'h0000);
    cnt(3);
    cw(2, WORD_UNLOCK_A, CODE_SECURE);
    send(OP_SEC_EXIT, 20'h00000, 16'h0000);
    cnt(4);
    cw(2, WORD_UNLOCK_A, CODE_IDENT);
    cd(3, CODE_EXIT);
    send(OP_QUERY, 20'h00000, 16'h0000);
    cnt(1);
    cw(0, WORD_QUERY_A, CODE_QUERY);
  endtask
  initial begin
    repeat (16) @(posedge REF_CLK);
    RST <= 1'b0;
    t_program();
    t_ident();
    t_fast();
    t_erase();
    t_secure();
    results();
  end
endmodule // tb
